// [rtl/lld_dma.sv]
// linked-descriptor dma: eight channel setups served by one engine, memory to peripheral
// assumes single-cycle-granted memory handshake (req held until ack) and async request pins
// Functional notes
// - reduced board: lines 0 rx, 1 tx, 2 card
// - emulation board: tiles 0-2, card 3, rx 4, tx 5
// - register bus always answers okay, never errors
// - packet is at most 4095 counted transfers
// - burst length up to 256, counted in destination writes; source burst code sets only the read burst type
// - engine picks the bus burst type itself
// - descriptor is four words: src, dst, next, control
// - next descriptor fetched automatically until chain ends
// - zero next pointer stops after that packet
// - widths 8, 16, 32; count in source transfers
// - control word gives bursts, widths, increments, ports
// - protection lines carry the packet's control value on data reads and writes; descriptor fetches drive 0
// - terminal count interrupt at packet end when enabled
// - looping chain repeats until software disables
// - eight channels, sixteen request and ack sets
// - exact transfer count, then stop regardless of requests
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module lld_dma #(
    parameter logic VARIANT = lld_pkg::BOARD_REDUCED
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // avalon-mm register slave
    input wire logic [6:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    output logic irq,
    // memory master (port bit picks master 0 or 1)
    output lld_pkg::lld_mreq_t mem,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // peripheral request pins
    input wire logic audio_receive_request,
    input wire logic audio_transmit_request,
    input wire logic card_interface_request,
    input wire logic [2:0] tile_request,
    input wire logic [9:0] other_request,
    output logic audio_receive_ack,
    output logic audio_transmit_ack,
    output logic card_interface_ack,
    output logic [2:0] tile_ack,
    output logic [9:0] other_ack
);
    lld_pkg::lld_eng_t e_r, e_nxt;
    lld_pkg::lld_cfg_t cfg;
    logic [lld_pkg::NUM_REQ-1:0] req_line;
    logic [lld_pkg::NUM_REQ-1:0] ack_line;
    logic [lld_pkg::NUM_CH-1:0] tc_evt;
    logic [lld_pkg::NUM_CH-1:0] en_clr;
    logic [31:0] eng_status;
    logic [2:0] pick;
    logic [1:0] swid;
    logic [1:0] dwid;
    logic [1:0] wwid;
    logic [1:0] last_piece;
    logic [8:0] dblen;
    logic [2:0] sbsz;
    logic [2:0] dbsz;
    logic sinc;
    logic dinc;
    logic tc_en;
    logic pkt_done;

    // burst code 0 is a single transfer, code n is 2 << n up to 256
    function automatic logic [8:0] blen(input logic [2:0] code);
        blen = (code == 3'h0) ? 9'h001 : (9'h002 << code);
    endfunction : blen

    // fixed address or single beats go out as singles, short bursts get a fixed type
    function automatic logic [2:0] btype(input logic [2:0] code, input logic inc);
        if (!inc || code == 3'h0) begin
            btype = lld_pkg::BURST_SINGLE;
        end else if (code == 3'h1) begin
            btype = lld_pkg::BURST_INCR4;
        end else if (code == 3'h2) begin
            btype = lld_pkg::BURST_INCR8;
        end else begin
            btype = lld_pkg::BURST_INCR;
        end
    endfunction : btype

    lld_reqmap #(.VARIANT(VARIANT)) u_map (
        .core_clk(core_clk),
        .resetn(resetn),
        .audio_receive_request(audio_receive_request),
        .audio_transmit_request(audio_transmit_request),
        .card_interface_request(card_interface_request),
        .tile_request(tile_request),
        .other_request(other_request),
        .audio_receive_ack(audio_receive_ack),
        .audio_transmit_ack(audio_transmit_ack),
        .card_interface_ack(card_interface_ack),
        .tile_ack(tile_ack),
        .other_ack(other_ack),
        .req_line(req_line),
        .ack_line(ack_line)
    );

    lld_regs u_regs (
        .core_clk(core_clk),
        .resetn(resetn),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .byteenable(byteenable),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .response(response),
        .tc_evt(tc_evt),
        .en_clr(en_clr),
        .eng_status(eng_status),
        .cfg(cfg),
        .irq(irq)
    );

    // control word decode for the packet in flight
    assign sbsz = e_r.ctrl[lld_pkg::CW_SBSIZE +: 3];
    assign dbsz = e_r.ctrl[lld_pkg::CW_DBSIZE +: 3];
    assign swid = e_r.ctrl[lld_pkg::CW_SWIDTH +: 2];
    assign dwid = e_r.ctrl[lld_pkg::CW_DWIDTH +: 2];
    assign sinc = e_r.ctrl[lld_pkg::CW_SINC];
    assign dinc = e_r.ctrl[lld_pkg::CW_DINC];
    assign tc_en = e_r.ctrl[lld_pkg::CW_TCEN];
    assign dblen = blen(dbsz);
    // a wider destination is written at source width, so one write per source item
    assign wwid = (dwid < swid) ? dwid : swid;
    assign last_piece = 2'((3'h1 << (swid - wwid)) - 3'h1);
    assign pkt_done = (e_r.cnt == 12'h000);
    assign eng_status = {23'h0, e_r.ch, e_r.st};

    // lowest enabled channel is served first and keeps the engine for its whole chain
    always_comb begin
        pick = 3'h0;
        for (int i = lld_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (cfg.en[i]) begin
                pick = 3'(i);
            end
        end
    end

    // memory request comes straight from engine flops
    always_comb begin
        mem = '0;
        mem.prot = e_r.ctrl[lld_pkg::CW_PROT +: 3];
        if (e_r.st == lld_pkg::ST_DESC) begin
            mem.req = 1'b1;
            mem.addr = e_r.ptr + {28'h0, e_r.widx, 2'h0};
            mem.size = 2'h2;
            mem.prot = '0;
            mem.burst = lld_pkg::BURST_INCR4;
        end else if (e_r.st == lld_pkg::ST_RD) begin
            mem.req = 1'b1;
            mem.addr = e_r.src;
            mem.size = swid;
            mem.port = e_r.ctrl[lld_pkg::CW_SMASTER];
            mem.burst = btype(sbsz, sinc);
        end else if (e_r.st == lld_pkg::ST_WR) begin
            mem.req = 1'b1;
            mem.we = 1'b1;
            mem.addr = e_r.dst;
            mem.size = wwid;
            mem.port = e_r.ctrl[lld_pkg::CW_DMASTER];
            mem.burst = btype(dbsz, dinc);
            mem.wdata = e_r.hold >> ({1'b0, e_r.piece, 3'h0} << wwid);
        end
    end

    // ack and events are pulses of the ack state
    always_comb begin
        ack_line = '0;
        tc_evt = '0;
        en_clr = '0;
        if (e_r.st == lld_pkg::ST_ACK) begin
            ack_line[cfg.line[e_r.ch]] = 1'b1;
            tc_evt[e_r.ch] = pkt_done & tc_en;
            en_clr[e_r.ch] = pkt_done && e_r.next == 32'h0;
        end
    end

    // engine sequence
    always_comb begin
        e_nxt = e_r;
        unique case (e_r.st)
            lld_pkg::ST_IDLE: begin
                if (|cfg.en) begin
                    e_nxt.ch = pick;
                    e_nxt.ptr = cfg.first[pick];
                    e_nxt.piece = 2'h0;
                    e_nxt.widx = 2'h0;
                    e_nxt.st = lld_pkg::ST_DESC;
                end
            end
            lld_pkg::ST_DESC: begin
                if (mem_ack) begin
                    e_nxt.widx = e_r.widx + 2'h1;
                    unique case (e_r.widx)
                        2'h0: e_nxt.src = mem_rdata;
                        2'h1: e_nxt.dst = mem_rdata;
                        2'h2: e_nxt.next = mem_rdata;
                        2'h3: begin
                            e_nxt.ctrl = mem_rdata;
                            e_nxt.cnt = mem_rdata[lld_pkg::CW_CNT +: 12];
                            e_nxt.bcnt = 9'h000;
                            e_nxt.st = lld_pkg::ST_WAIT;
                            // an empty packet completes at once
                            if (mem_rdata[lld_pkg::CW_CNT +: 12] == 12'h000) begin
                                e_nxt.st = lld_pkg::ST_ACK;
                            end
                        end
                    endcase
                end
            end
            lld_pkg::ST_WAIT: begin
                if (!cfg.en[e_r.ch]) begin
                    e_nxt.st = lld_pkg::ST_IDLE;
                end else if (req_line[cfg.line[e_r.ch]]) begin
                    // a burst cut between pieces resumes the held source item
                    e_nxt.st = (e_r.piece != 2'h0) ? lld_pkg::ST_WR : lld_pkg::ST_RD;
                end
            end
            lld_pkg::ST_RD: begin
                if (mem_ack) begin
                    e_nxt.hold = mem_rdata;
                    e_nxt.piece = 2'h0;
                    e_nxt.src = sinc ? e_r.src + (32'h1 << swid) : e_r.src;
                    e_nxt.st = lld_pkg::ST_WR;
                end
            end
            lld_pkg::ST_WR: begin
                if (mem_ack) begin
                    e_nxt.dst = dinc ? e_r.dst + (32'h1 << wwid) : e_r.dst;
                    e_nxt.piece = e_r.piece + 2'h1;
                    e_nxt.bcnt = e_r.bcnt + 9'h001;
                    if (e_r.piece == last_piece) begin
                        e_nxt.cnt = e_r.cnt - 12'h001;
                        e_nxt.piece = 2'h0;
                        e_nxt.st = lld_pkg::ST_RD;
                    end
                    // burst closes on its length or on packet end, never on requests
                    if ((e_r.piece == last_piece && e_r.cnt == 12'h001) || e_r.bcnt + 9'h001 >= dblen) begin
                        e_nxt.st = lld_pkg::ST_ACK;
                    end
                end
            end
            lld_pkg::ST_ACK: begin
                e_nxt.bcnt = 9'h000;
                if (!cfg.en[e_r.ch]) begin
                    e_nxt.st = lld_pkg::ST_IDLE;
                end else if (!pkt_done) begin
                    e_nxt.st = lld_pkg::ST_WAIT;
                end else if (e_r.next == 32'h0) begin
                    e_nxt.st = lld_pkg::ST_IDLE;
                end else begin
                    e_nxt.ptr = e_r.next;
                    e_nxt.widx = 2'h0;
                    e_nxt.st = lld_pkg::ST_DESC;
                end
            end
            default: e_nxt.st = lld_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            e_r <= '0;
            e_r.st <= lld_pkg::ST_IDLE;
        end else begin
            e_r <= e_nxt;
        end
    end

    // checks on the engine
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    chk_desc_four: assert property (
        (e_r.st == lld_pkg::ST_DESC && mem_ack && e_r.widx == 2'h3) |=> e_r.st != lld_pkg::ST_DESC)
        else $error("descriptor fetch did not end after four words");
    chk_next_fetch: assert property (
        (e_r.st == lld_pkg::ST_ACK && pkt_done && e_r.next != 32'h0 && cfg.en[e_r.ch])
        |=> (e_r.st == lld_pkg::ST_DESC && e_r.ptr == $past(e_r.next) && e_r.widx == 2'h0))
        else $error("next descriptor not fetched");
    chk_chain_stop: assert property (
        (e_r.st == lld_pkg::ST_ACK && pkt_done && e_r.next == 32'h0)
        |-> en_clr[e_r.ch] ##1 e_r.st == lld_pkg::ST_IDLE)
        else $error("chain did not stop on zero next");
    chk_prot_drive: assert property (
        (mem.req && e_r.st != lld_pkg::ST_DESC) |-> mem.prot == e_r.ctrl[lld_pkg::CW_PROT +: 3])
        else $error("protection value differs from control word");
    chk_tc_cause: assert property (
        (|tc_evt) |-> (tc_en && pkt_done && ($past(e_r.st) == lld_pkg::ST_WR || $past(e_r.st) == lld_pkg::ST_DESC)))
        else $error("terminal count without packet end");
    chk_count_exact: assert property (
        (e_r.st == lld_pkg::ST_RD || e_r.st == lld_pkg::ST_WAIT) |-> e_r.cnt != 12'h000)
        else $error("transfer started after count reached zero");
    chk_burst_len: assert property (
        (e_r.st == lld_pkg::ST_WR && mem_ack) |-> e_r.bcnt < dblen)
        else $error("burst longer than programmed");
    chk_burst_type: assert property (
        (e_r.st == lld_pkg::ST_WR && !dinc) |-> mem.burst == lld_pkg::BURST_SINGLE)
        else $error("fixed address side given a burst");
    chk_ack_pulse: assert property (
        (|ack_line) |=> ack_line == '0)
        else $error("acknowledge longer than one cycle");
    chk_width_legal: assert property (
        (e_r.st == lld_pkg::ST_WR) |-> (mem.size <= swid && mem.size <= 2'h2))
        else $error("destination write width out of range");
endmodule : lld_dma

// [rtl/lld_pkg.sv]
// constants, field layouts and carrier types for the linked-descriptor dma channel block
// assumes one 100 MHz clock and an avalon-mm register master in the same domain
package lld_pkg;
    localparam int NUM_CH = 8;
    localparam int NUM_REQ = 16;
    localparam logic [11:0] MAX_XFER = 12'hFFF;
    // board variants of the request line wiring
    localparam logic BOARD_REDUCED = 1'b0;
    localparam logic BOARD_EMUL = 1'b1;
    localparam int RED_LINE_RX = 0;
    localparam int RED_LINE_TX = 1;
    localparam int RED_LINE_CARD = 2;
    localparam int EMU_LINE_TILE = 0;
    localparam int EMU_LINE_CARD = 3;
    localparam int EMU_LINE_RX = 4;
    localparam int EMU_LINE_TX = 5;
    localparam int EMU_LINE_OTHER = 6;
    // register byte offsets
    localparam logic [6:0] OFS_INT_STATUS = 7'h00;
    localparam logic [6:0] OFS_INT_MASK = 7'h04;
    localparam logic [6:0] OFS_ENABLE = 7'h08;
    localparam logic [6:0] OFS_STATUS = 7'h0C;
    localparam logic [6:0] OFS_CH_BASE = 7'h40;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // channel_packet_control_word fields
    localparam int CW_CNT = 0;
    localparam int CW_SBSIZE = 12;
    localparam int CW_DBSIZE = 15;
    localparam int CW_SWIDTH = 18;
    localparam int CW_DWIDTH = 21;
    localparam int CW_SMASTER = 24;
    localparam int CW_DMASTER = 25;
    localparam int CW_SINC = 26;
    localparam int CW_DINC = 27;
    localparam int CW_PROT = 28;
    localparam int CW_TCEN = 31;
    // bus burst codes chosen by the engine
    localparam logic [2:0] BURST_SINGLE = 3'h0;
    localparam logic [2:0] BURST_INCR = 3'h1;
    localparam logic [2:0] BURST_INCR4 = 3'h3;
    localparam logic [2:0] BURST_INCR8 = 3'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DESC = 6'h02,
        ST_WAIT = 6'h04,
        ST_RD = 6'h08,
        ST_WR = 6'h10,
        ST_ACK = 6'h20
    } lld_state_t;

    typedef struct packed {
        logic [NUM_CH-1:0] en;
        logic [NUM_CH-1:0][31:0] first;
        logic [NUM_CH-1:0][3:0] line;
    } lld_cfg_t;

    typedef struct packed {
        logic req;
        logic we;
        logic port;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [1:0] size;
        logic [2:0] prot;
        logic [2:0] burst;
    } lld_mreq_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [NUM_CH-1:0] mask;
        logic [NUM_CH-1:0] stat;
        logic [NUM_CH-1:0] en;
        logic [NUM_CH-1:0][31:0] first;
        logic [NUM_CH-1:0][3:0] line;
    } lld_regs_t;

    typedef struct packed {
        lld_state_t st;
        logic [2:0] ch;
        logic [1:0] widx;
        logic [31:0] ptr;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] next;
        logic [31:0] ctrl;
        logic [11:0] cnt;
        logic [1:0] piece;
        logic [8:0] bcnt;
        logic [31:0] hold;
    } lld_eng_t;

    typedef struct packed {
        logic [NUM_REQ-1:0] s1;
        logic [NUM_REQ-1:0] s2;
    } lld_sync_t;
endpackage : lld_pkg

// [rtl/lld_regs.sv]
// avalon-mm register slave: interrupt status/mask, channel enables, per-channel setup
// assumes a master that holds its request until waitrequest is seen low
`timescale 1ns/1ps
module lld_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [6:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    // engine side
    input wire logic [lld_pkg::NUM_CH-1:0] tc_evt,
    input wire logic [lld_pkg::NUM_CH-1:0] en_clr,
    input wire logic [31:0] eng_status,
    output lld_pkg::lld_cfg_t cfg,
    output logic irq
);
    lld_pkg::lld_regs_t r_r, r_nxt;
    logic hit;
    logic [2:0] chi;
    logic [31:0] bm;

    // one wait cycle: the answer comes with the internal ack flop
    assign waitrequest = (read | write) & ~r_r.ack;
    assign response = lld_pkg::RESP_OKAY;
    assign readdata = r_r.rdata;
    assign irq = |(r_r.stat & r_r.mask);
    assign cfg.en = r_r.en;
    assign cfg.first = r_r.first;
    assign cfg.line = r_r.line;
    assign chi = address[5:3];
    assign bm = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};

    always_comb begin
        r_nxt = r_r;
        hit = (read | write) & ~r_r.ack;
        r_nxt.ack = hit;
        // hardware clears an enable when its chain ends; a write in the same cycle wins
        r_nxt.en = r_r.en & ~en_clr;
        r_nxt.rdata = lld_pkg::RST_WORD;
        if (hit && read) begin
            if (address == lld_pkg::OFS_INT_STATUS) begin
                r_nxt.rdata[7:0] = r_r.stat;
                r_nxt.stat = '0;
            end else if (address == lld_pkg::OFS_INT_MASK) begin
                r_nxt.rdata[7:0] = r_r.mask;
            end else if (address == lld_pkg::OFS_ENABLE) begin
                r_nxt.rdata[7:0] = r_r.en;
            end else if (address == lld_pkg::OFS_STATUS) begin
                r_nxt.rdata = eng_status;
            end else if (address[6] && !address[2]) begin
                r_nxt.rdata = r_r.first[chi];
            end else if (address[6]) begin
                r_nxt.rdata[3:0] = r_r.line[chi];
            end
        end
        // a write lands only at the edge where the master sees waitrequest low
        if (write && r_r.ack) begin
            if (address == lld_pkg::OFS_INT_MASK && byteenable[0]) begin
                r_nxt.mask = writedata[7:0];
            end else if (address == lld_pkg::OFS_ENABLE && byteenable[0]) begin
                r_nxt.en = writedata[7:0];
            end else if (address[6] && !address[2]) begin
                r_nxt.first[chi] = (r_r.first[chi] & ~bm) | (writedata & bm);
            end else if (address[6] && byteenable[0]) begin
                r_nxt.line[chi] = writedata[3:0];
            end
        end
        // a terminal count arriving with the clearing read is kept
        r_nxt.stat = r_nxt.stat | tc_evt;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end
endmodule : lld_regs

// [rtl/lld_reqmap.sv]
// fixed peripheral request wiring for the two board variants, with pin synchronisers
// assumes request pins are asynchronous and acks are one-cycle pulses from the engine
`timescale 1ns/1ps
module lld_reqmap #(
    parameter logic VARIANT = lld_pkg::BOARD_REDUCED
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // peripheral pins
    input wire logic audio_receive_request,
    input wire logic audio_transmit_request,
    input wire logic card_interface_request,
    input wire logic [2:0] tile_request,
    input wire logic [9:0] other_request,
    output logic audio_receive_ack,
    output logic audio_transmit_ack,
    output logic card_interface_ack,
    output logic [2:0] tile_ack,
    output logic [9:0] other_ack,
    // engine side
    output logic [lld_pkg::NUM_REQ-1:0] req_line,
    input wire logic [lld_pkg::NUM_REQ-1:0] ack_line
);
    lld_pkg::lld_sync_t st_r, st_nxt;
    logic [lld_pkg::NUM_REQ-1:0] raw;

    // pin wiring is fixed per variant; each channel picks its request line through its line register
    always_comb begin
        raw = '0;
        if (VARIANT == lld_pkg::BOARD_REDUCED) begin
            raw[lld_pkg::RED_LINE_RX] = audio_receive_request;
            raw[lld_pkg::RED_LINE_TX] = audio_transmit_request;
            raw[lld_pkg::RED_LINE_CARD] = card_interface_request;
        end else begin
            raw[lld_pkg::EMU_LINE_TILE +: 3] = tile_request;
            raw[lld_pkg::EMU_LINE_CARD] = card_interface_request;
            raw[lld_pkg::EMU_LINE_RX] = audio_receive_request;
            raw[lld_pkg::EMU_LINE_TX] = audio_transmit_request;
            raw[lld_pkg::EMU_LINE_OTHER +: 10] = other_request;
        end
        st_nxt.s1 = raw;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign req_line = st_r.s2;

    // acks go back on the same fixed wiring
    always_comb begin
        tile_ack = '0;
        other_ack = '0;
        if (VARIANT == lld_pkg::BOARD_REDUCED) begin
            audio_receive_ack = ack_line[lld_pkg::RED_LINE_RX];
            audio_transmit_ack = ack_line[lld_pkg::RED_LINE_TX];
            card_interface_ack = ack_line[lld_pkg::RED_LINE_CARD];
        end else begin
            tile_ack = ack_line[lld_pkg::EMU_LINE_TILE +: 3];
            card_interface_ack = ack_line[lld_pkg::EMU_LINE_CARD];
            audio_receive_ack = ack_line[lld_pkg::EMU_LINE_RX];
            audio_transmit_ack = ack_line[lld_pkg::EMU_LINE_TX];
            other_ack = ack_line[lld_pkg::EMU_LINE_OTHER +: 10];
        end
    end
endmodule : lld_reqmap

// [sim/linked_list_dma_channel_bench.sv]
// self-checking bench: two-descriptor chains on channel 0, line 1, reduced board
// assumes the far model answers memory and raises the transmit request
`timescale 1ns/1ps
module linked_list_dma_channel_bench;
    logic core_clk, resetn, read, write, slow, waitrequest, irq, mem_ack, tx_req, tx_ack;
    logic [6:0] address;
    logic [31:0] writedata, readdata, rd, lf, ctl, mem_rdata;
    logic [1:0] response;
    lld_pkg::lld_mreq_t mem;
    int fails, compares, cyc, n;
    lld_dma dut (.core_clk(core_clk), .resetn(resetn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .response(response), .irq(irq), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .audio_receive_request(1'b0), .audio_transmit_request(tx_req), .card_interface_request(1'b0),
        .tile_request(3'h0), .other_request(10'h000), .audio_receive_ack(), .audio_transmit_ack(tx_ack),
        .card_interface_ack(), .tile_ack(), .other_ack());
    lld_far_model u_far (.core_clk(core_clk), .resetn(resetn), .mem(mem), .slow(slow), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .ack_in(tx_ack), .req_out(tx_req));
    function logic [31:0] nx(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    // halfword k: low half of source word k/2 first, destination packed contiguously
    function logic [31:0] expw(int k, logic [2:0] p);
        logic [31:0] a, s;
        a = 32'h200 + 32'(4 * (k / 2));
        s = {~a[15:0], a[15:0] ^ 16'h5A5A};
        a = 32'h300 + 32'(2 * k);
        return {p, 2'h1, a[10:0], (k % 2) ? s[31:16] : s[15:0]};
    endfunction : expw
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one avalon access, held until waitrequest is seen low
    task bus(logic w, logic [6:0] a, logic [31:0] d);
        @(posedge core_clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do @(posedge core_clk); while (waitrequest !== 1'b0 && cyc < 30000);
        rd = readdata;
        chk("response", 32'h0, {30'h0, response});
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task tally_and_finish;
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        {resetn, read, write, slow, address, writedata} = '0;
        lf = 32'h02f6;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        bus(1'b1, 7'h30, 32'hFFFF_FFFF);
        bus(1'b0, 7'h30, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b0, lld_pkg::OFS_INT_MASK, 32'h0);
        chk("mask reset", 32'h0, rd);
        bus(1'b1, lld_pkg::OFS_INT_MASK, 32'h1);
        for (int it = 0; it < 3; it++) begin
            lf = nx(lf);
            n = int'(lf[2:0]) + 1;
            slow <= lf[3];
            ctl = {1'b0, lf[6:4], 4'hC, 3'h1, 3'h2, 1'b0, 2'(it), 3'h0, 12'(n)}; // dst bursts of 1, 4, 8
            u_far.m[0] = 32'h200;
            u_far.m[1] = 32'h300;
            u_far.m[2] = 32'h110;
            u_far.m[3] = ctl;
            u_far.m[4] = 32'h200 + 32'(4 * n);
            u_far.m[5] = 32'h300 + 32'(4 * n);
            u_far.m[6] = 32'h0;
            u_far.m[7] = ctl | 32'h8000_0000;
            u_far.wlog.delete();
            bus(1'b1, lld_pkg::OFS_CH_BASE, 32'h100);
            bus(1'b1, lld_pkg::OFS_CH_BASE + 7'h04, 32'h1);
            bus(1'b1, lld_pkg::OFS_ENABLE, 32'h1);
            for (int t = 0; t < 4000 && irq !== 1'b1; t++) @(posedge core_clk);
            chk("irq", 32'h1, {31'h0, irq});
            chk("writes", 32'(4 * n), 32'(u_far.wlog.size()));
            for (int k = 0; k < 4 * n && k < u_far.wlog.size(); k++) chk("write", expw(k, lf[6:4]), u_far.wlog[k]);
            bus(1'b0, lld_pkg::OFS_ENABLE, 32'h0);
            chk("enable", 32'h0, rd);
            bus(1'b0, lld_pkg::OFS_INT_STATUS, 32'h0);
            chk("status", 32'h1, rd);
            bus(1'b0, lld_pkg::OFS_INT_STATUS, 32'h0);
            chk("status cleared", 32'h0, rd);
            chk("irq low", 32'h0, {31'h0, irq});
        end
        tally_and_finish();
    end
endmodule : linked_list_dma_channel_bench

// [sim/lld_far_model.sv]
// memory and audio transmit peripheral standing on the far side of the dma channel
// assumes one clock; descriptors sit at word index addr[7:2], sample words at addr[9] set
`timescale 1ns/1ps
module lld_far_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // memory side
    input wire lld_pkg::lld_mreq_t mem,
    input wire logic slow,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    // peripheral pins
    input wire logic ack_in,
    output logic req_out
);
    logic [31:0] m [0:63];
    logic [31:0] wlog [$];
    logic [1:0] w;
    // answers each held request after 0 or 3 wait cycles; logs every write
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
            w <= 2'h0;
            req_out <= 1'b0;
        end else begin
            req_out <= !ack_in;
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata; // stale data must never look valid
            if (mem.req && !mem_ack) begin
                if (w != 2'h0) begin
                    w <= w - 2'h1;
                end else begin
                    mem_ack <= 1'b1;
                    w <= {slow, slow};
                    if (mem.we) wlog.push_back({mem.prot, mem.size, mem.addr[10:0], mem.wdata[15:0]});
                    else mem_rdata <= mem.addr[9] ? {~mem.addr[15:0], mem.addr[15:0] ^ 16'h5A5A} : m[mem.addr[7:2]];
                end
            end
        end
    end
endmodule : lld_far_model
